// >>> pkg/isl_defs.svh
// constants for the switch and lamp controller
`ifndef ISL_DEFS_SVH
`define ISL_DEFS_SVH

// ***************************************************************
// clock and timing
// ***************************************************************
`define ISL_CLK_HZ 40000000
`define ISL_TICK_MS 50
`define ISL_TICK_CYC (`ISL_TICK_MS * (`ISL_CLK_HZ / 1000))
`define ISL_DEBOUNCE_MS 10
`define ISL_DEBOUNCE_CYC (`ISL_DEBOUNCE_MS * (`ISL_CLK_HZ / 1000))
`define ISL_STRETCH_MS 50
`define ISL_STRETCH_CYC (`ISL_STRETCH_MS * (`ISL_CLK_HZ / 1000))
`define ISL_HALF_SEC_MS 500
`define ISL_ONE_SEC_MS 1000
`define ISL_FATAL_PERIOD_MS 2500
`define ISL_FATAL_FLASH_MS 100
`define ISL_REBIND_HOLD_MS 2000
`define ISL_HALF_SEC_TICKS 8'(`ISL_HALF_SEC_MS / `ISL_TICK_MS)
`define ISL_ONE_SEC_TICKS 8'(`ISL_ONE_SEC_MS / `ISL_TICK_MS)
`define ISL_FATAL_PERIOD_TICKS 8'(`ISL_FATAL_PERIOD_MS / `ISL_TICK_MS)
`define ISL_FATAL_FLASH_TICKS 8'(`ISL_FATAL_FLASH_MS / `ISL_TICK_MS)
`define ISL_REBIND_TICKS 8'(`ISL_REBIND_HOLD_MS / `ISL_TICK_MS)
`define ISL_PATTERN_TICKS 8'hC8

// ***************************************************************
// switch bank layout and reset values
// ***************************************************************
`define ISL_ADDR_LSB 0
`define ISL_ADDR_MSB 3
`define ISL_BIND_LSB 4
`define ISL_BIND_MSB 6
`define ISL_SWITCH_RST 8'h08

// ***************************************************************
// register map
// ***************************************************************
`define ISL_CTRL_OFS 12'h000
`define ISL_RELAY_OFS 12'h004
`define ISL_STATUS_OFS 12'h008
`define ISL_CTRL_LAMP_TEST 0
`define ISL_CTRL_RST 32'h0000_0000
`define ISL_RELAY_RST 16'h0000

`endif

// >>> pkg/isl_pkg.sv
// types for the switch and lamp controller
package isl_pkg;

  typedef enum logic [1:0] {
    ISL_BLINK_ON,
    ISL_BLINK_OFF,
    ISL_PAUSE
  } isl_seq_t;

  typedef enum logic [1:0] {
    ISL_NET_OFF,
    ISL_NET_RED,
    ISL_NET_GREEN,
    ISL_NET_ORANGE
  } isl_net_t;

endpackage

// >>> core/isl_debounce.sv
// debounce filter for a group of switch inputs
`timescale 1ns/1ps
module isl_debounce #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned CYC = 400000,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] stable
);

  logic [31:0] cnt_q;
  logic [WIDTH-1:0] stable_q;
  wire differ = (raw != stable_q);
  wire settled = (cnt_q >= 32'(CYC - 1));

  // accept raw once it has differed from the stable value for the whole window
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 32'h0000_0000;
      stable_q <= RST_VAL;
    end else if (!differ) begin
      cnt_q <= 32'h0000_0000;
    end else if (settled) begin
      cnt_q <= 32'h0000_0000;
      stable_q <= raw;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  assign stable = stable_q;

endmodule

// >>> core/isl_lamp_ctrl.sv
// switch decoding and lamp control with an apb register file
//
// Functional notes
// - node address from switches one to four, default pattern 1000
// - autobinding selection from switches five to seven
// - switch eight ignored
// - service lamp on while button held; press gives identification pulse
// - reset pushbutton resets the node processor
// - status lamp blinks 1 Hz while application code runs
// - self-installed: blink address times, dark one second, repeat
// - service lamp off when application present and installed
// - service lamp steady on when no application or stopping error
// - service lamp blinks 1 s on 1 s off when not installed
// - fatal watchdog error: one brief service flash per 2.5 s
// - network lamp red when integrity test failed
// - network lamp green when test passed and network normal
// - network lamp orange while node has no bindings and integrity test not failed
// - network activity lamp flashes on each network communication
// - expansion lamp flashes on each expansion communication
// - eight relay lamps follow the relay coil states
// - address zero: drop bindings, no status blink, no binding
// - each relay command update sets the matching relay
`timescale 1ns/1ps
`include "isl_defs.svh"
module isl_lamp_ctrl #(
  parameter int unsigned TICK_CYC = `ISL_TICK_CYC,
  parameter int unsigned DEBOUNCE_CYC = `ISL_DEBOUNCE_CYC,
  parameter int unsigned STRETCH_CYC = `ISL_STRETCH_CYC,
  parameter int unsigned RELAYS = 16
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic [7:0] NODE_SWITCH_BANK,
  input wire logic SERVICE_PUSHBUTTON,
  input wire logic PROCESSOR_RESET_PUSHBUTTON,
  input wire logic APP_RUNNING,
  input wire logic APP_PRESENT,
  input wire logic APP_ERROR,
  input wire logic NODE_INSTALLED,
  input wire logic SELF_INSTALLED,
  input wire logic WDOG_FATAL,
  input wire logic NET_TEST_FAIL,
  input wire logic NET_TEST_PASS,
  input wire logic NODE_BOUND,
  input wire logic NET_ACTIVITY_EVENT,
  input wire logic EXP_ACTIVITY_EVENT,
  input wire logic [7:0] RELAY_COIL,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [3:0] NODE_ADDRESS,
  output logic [2:0] AUTOBIND_SEL,
  output logic REMOVE_BINDINGS,
  output logic BIND_ENABLE,
  output logic SERVICE_ID_EVENT,
  output logic REBIND_REQUEST,
  output logic PROCESSOR_RESET_N,
  output logic [RELAYS-1:0] RELAY_DRIVE,
  output logic STATUS_LAMP,
  output logic SERVICE_LAMP,
  output logic NET_ERROR_RED,
  output logic NET_ERROR_GREEN,
  output logic NET_ACTIVITY_LAMP,
  output logic EXPANSION_LAMP,
  output logic RELAY_ONE_LAMP,
  output logic RELAY_TWO_LAMP,
  output logic RELAY_THREE_LAMP,
  output logic RELAY_FOUR_LAMP,
  output logic RELAY_FIVE_LAMP,
  output logic RELAY_SIX_LAMP,
  output logic RELAY_SEVEN_LAMP,
  output logic RELAY_EIGHT_LAMP
);

  // ***************************************************************
  // input debouncing
  // ***************************************************************
  logic [7:0] switch_bank;
  logic [1:0] buttons;

  isl_debounce #(
    .WIDTH(8),
    .CYC(DEBOUNCE_CYC),
    .RST_VAL(`ISL_SWITCH_RST)
  ) u_switch_deb (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .raw(NODE_SWITCH_BANK),
    .stable(switch_bank)
  );

  isl_debounce #(
    .WIDTH(2),
    .CYC(DEBOUNCE_CYC),
    .RST_VAL(2'h0)
  ) u_button_deb (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .raw({PROCESSOR_RESET_PUSHBUTTON, SERVICE_PUSHBUTTON}),
    .stable(buttons)
  );

  wire service_held = buttons[0];
  wire reset_held = buttons[1];
  // switch eight is never decoded
  wire [3:0] addr = switch_bank[`ISL_ADDR_MSB:`ISL_ADDR_LSB];
  wire [2:0] bind_sel = switch_bank[`ISL_BIND_MSB:`ISL_BIND_LSB];
  wire addr_zero = (addr == 4'h0);

  // ***************************************************************
  // time base
  // ***************************************************************
  logic [31:0] tick_cnt_q;
  logic [7:0] pat_q;
  wire tick = (tick_cnt_q >= 32'(TICK_CYC - 1));

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // common multiple of all periodic patterns, in ticks
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      pat_q <= 8'h00;
    end else if (tick) begin
      pat_q <= (pat_q == `ISL_PATTERN_TICKS - 8'h01) ? 8'h00 : pat_q + 8'h01;
    end
  end

  // phase of a square wave with given half period, in ticks
  function automatic logic square(input logic [7:0] pos,
                                  input logic [7:0] half);
    logic [7:0] two;
    two = 8'(half << 1);
    square = ((pos % two) < half);
  endfunction

  wire blink_1hz = square(pat_q, `ISL_HALF_SEC_TICKS);
  wire blink_half_hz = square(pat_q, `ISL_ONE_SEC_TICKS);
  wire fatal_flash =
    ((pat_q % `ISL_FATAL_PERIOD_TICKS) < `ISL_FATAL_FLASH_TICKS);

  // ***************************************************************
  // self-installed status sequence
  // ***************************************************************
  isl_pkg::isl_seq_t seq_q;
  isl_pkg::isl_seq_t seq_d;
  logic [7:0] seq_cnt_q;
  logic [7:0] seq_cnt_d;
  logic [3:0] blinks_q;
  logic [3:0] blinks_d;
  wire seq_run = SELF_INSTALLED && !addr_zero;
  wire [7:0] seq_len = (seq_q == isl_pkg::ISL_PAUSE) ?
    `ISL_ONE_SEC_TICKS : `ISL_HALF_SEC_TICKS;
  wire seq_end = tick && (seq_cnt_q == seq_len - 8'h01);

  always_comb begin
    seq_d = seq_q;
    blinks_d = blinks_q;
    seq_cnt_d = tick ? seq_cnt_q + 8'h01 : seq_cnt_q;
    if (!seq_run) begin
      seq_d = isl_pkg::ISL_BLINK_ON;
      blinks_d = 4'h0;
      seq_cnt_d = 8'h00;
    end else if (seq_end) begin
      seq_cnt_d = 8'h00;
      unique case (seq_q)
        isl_pkg::ISL_BLINK_ON: begin
          seq_d = isl_pkg::ISL_BLINK_OFF;
          blinks_d = blinks_q + 4'h1;
        end
        isl_pkg::ISL_BLINK_OFF: begin
          seq_d = (blinks_q >= addr) ? isl_pkg::ISL_PAUSE :
                                       isl_pkg::ISL_BLINK_ON;
        end
        isl_pkg::ISL_PAUSE: begin
          seq_d = isl_pkg::ISL_BLINK_ON;
          blinks_d = 4'h0;
        end
        default: begin
          seq_d = isl_pkg::ISL_BLINK_ON;
          blinks_d = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      seq_q <= isl_pkg::ISL_BLINK_ON;
      seq_cnt_q <= 8'h00;
      blinks_q <= 4'h0;
    end else begin
      seq_q <= seq_d;
      seq_cnt_q <= seq_cnt_d;
      blinks_q <= blinks_d;
    end
  end

  // ***************************************************************
  // service button events
  // ***************************************************************
  logic service_prev_q;
  logic [7:0] hold_q;
  logic rebind_done_q;
  wire service_press = service_held && !service_prev_q;
  wire hold_reached = (hold_q == `ISL_REBIND_TICKS);
  wire rebind_fire = hold_reached && !rebind_done_q && !addr_zero;

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      service_prev_q <= 1'b0;
      hold_q <= 8'h00;
      rebind_done_q <= 1'b0;
    end else begin
      service_prev_q <= service_held;
      if (!service_held) begin
        hold_q <= 8'h00;
        rebind_done_q <= 1'b0;
      end else begin
        if (tick && !hold_reached) begin
          hold_q <= hold_q + 8'h01;
        end
        if (hold_reached) begin
          rebind_done_q <= 1'b1;
        end
      end
    end
  end

  // ***************************************************************
  // activity stretchers
  // ***************************************************************
  logic [31:0] stretch_q [2];
  wire [1:0] act_event = {EXP_ACTIVITY_EVENT, NET_ACTIVITY_EVENT};

  always_ff @(posedge CLOCK) begin
    for (int i = 0; i < 2; i++) begin
      if (!RESET_N) begin
        stretch_q[i] <= 32'h0000_0000;
      end else if (act_event[i]) begin
        stretch_q[i] <= 32'(STRETCH_CYC);
      end else if (stretch_q[i] != 32'h0000_0000) begin
        stretch_q[i] <= stretch_q[i] - 32'h0000_0001;
      end
    end
  end

  // ***************************************************************
  // lamp decoding
  // ***************************************************************
  logic [31:0] ctrl_q;
  logic [RELAYS-1:0] relay_q;
  wire lamp_test = ctrl_q[`ISL_CTRL_LAMP_TEST];

  wire status_d = addr_zero ? 1'b0 :
    seq_run ? (seq_q == isl_pkg::ISL_BLINK_ON) :
    (APP_RUNNING && blink_1hz);

  wire service_d = service_held ? 1'b1 :
    WDOG_FATAL ? fatal_flash :
    (!APP_PRESENT || APP_ERROR) ? 1'b1 :
    !NODE_INSTALLED ? blink_half_hz :
    1'b0;

  wire isl_pkg::isl_net_t net_d =
    NET_TEST_FAIL ? isl_pkg::ISL_NET_RED :
    !NODE_BOUND ? isl_pkg::ISL_NET_ORANGE :
    NET_TEST_PASS ? isl_pkg::ISL_NET_GREEN :
    isl_pkg::ISL_NET_OFF;

  wire red_d = (net_d == isl_pkg::ISL_NET_RED) ||
               (net_d == isl_pkg::ISL_NET_ORANGE);
  wire green_d = (net_d == isl_pkg::ISL_NET_GREEN) ||
                 (net_d == isl_pkg::ISL_NET_ORANGE);
  wire net_act_d = (stretch_q[0] != 32'h0000_0000);
  wire exp_act_d = (stretch_q[1] != 32'h0000_0000);
  wire [7:0] relay_lamp_d = lamp_test ? 8'hFF : RELAY_COIL;

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      STATUS_LAMP <= 1'b0;
      SERVICE_LAMP <= 1'b0;
      NET_ERROR_RED <= 1'b0;
      NET_ERROR_GREEN <= 1'b0;
      NET_ACTIVITY_LAMP <= 1'b0;
      EXPANSION_LAMP <= 1'b0;
    end else begin
      STATUS_LAMP <= lamp_test || status_d;
      SERVICE_LAMP <= lamp_test || service_d;
      NET_ERROR_RED <= lamp_test || red_d;
      NET_ERROR_GREEN <= lamp_test || green_d;
      NET_ACTIVITY_LAMP <= lamp_test || net_act_d;
      EXPANSION_LAMP <= lamp_test || exp_act_d;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      {RELAY_EIGHT_LAMP, RELAY_SEVEN_LAMP, RELAY_SIX_LAMP, RELAY_FIVE_LAMP,
       RELAY_FOUR_LAMP, RELAY_THREE_LAMP, RELAY_TWO_LAMP,
       RELAY_ONE_LAMP} <= 8'h00;
    end else begin
      {RELAY_EIGHT_LAMP, RELAY_SEVEN_LAMP, RELAY_SIX_LAMP, RELAY_FIVE_LAMP,
       RELAY_FOUR_LAMP, RELAY_THREE_LAMP, RELAY_TWO_LAMP,
       RELAY_ONE_LAMP} <= relay_lamp_d;
    end
  end

  // ***************************************************************
  // node outputs
  // ***************************************************************
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      NODE_ADDRESS <= 4'h0;
      AUTOBIND_SEL <= 3'h0;
      REMOVE_BINDINGS <= 1'b0;
      BIND_ENABLE <= 1'b0;
      SERVICE_ID_EVENT <= 1'b0;
      REBIND_REQUEST <= 1'b0;
      PROCESSOR_RESET_N <= 1'b0;
      RELAY_DRIVE <= '0;
    end else begin
      NODE_ADDRESS <= addr;
      AUTOBIND_SEL <= bind_sel;
      REMOVE_BINDINGS <= addr_zero;
      BIND_ENABLE <= !addr_zero;
      SERVICE_ID_EVENT <= service_press;
      REBIND_REQUEST <= rebind_fire;
      PROCESSOR_RESET_N <= !reset_held;
      RELAY_DRIVE <= relay_q;
    end
  end

  // ***************************************************************
  // apb register file
  // ***************************************************************
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  wire setup = PSEL && !PENABLE;
  wire hit_ctrl = (PADDR == `ISL_CTRL_OFS);
  wire hit_relay = (PADDR == `ISL_RELAY_OFS);
  wire hit_status = (PADDR == `ISL_STATUS_OFS);
  wire mapped = hit_ctrl || hit_relay || (hit_status && !PWRITE);
  wire commit = PSEL && PENABLE && pready_q && PWRITE && !pslverr_q;
  wire [31:0] status_word = {16'h0000, 1'b0, REMOVE_BINDINGS,
    NET_ERROR_GREEN, NET_ERROR_RED, SERVICE_LAMP, STATUS_LAMP,
    reset_held, service_held, switch_bank};
  wire [31:0] rd_word = hit_ctrl ? ctrl_q :
    hit_relay ? 32'(relay_q) :
    hit_status ? status_word : 32'h0000_0000;

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !mapped;
        prdata_q <= (mapped && !PWRITE) ? rd_word : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      ctrl_q <= `ISL_CTRL_RST;
      relay_q <= `ISL_RELAY_RST;
    end else if (commit) begin
      if (hit_ctrl) begin
        ctrl_q <= {31'h0000_0000, PWDATA[`ISL_CTRL_LAMP_TEST]};
      end
      if (hit_relay) begin
        relay_q <= PWDATA[RELAYS-1:0];
      end
    end
  end

  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;

endmodule

// >>> verif/isl_lamp_ctrl_assertions.sv
// assertion checker for the switch and lamp controller
`timescale 1ns/1ps
module isl_lamp_ctrl_assertions (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic PROCESSOR_RESET_PUSHBUTTON,
  input wire logic APP_PRESENT,
  input wire logic WDOG_FATAL,
  input wire logic NET_TEST_FAIL,
  input wire logic NODE_BOUND,
  input wire logic NET_ACTIVITY_EVENT,
  input wire logic EXP_ACTIVITY_EVENT,
  input wire logic [7:0] RELAY_COIL,
  input wire logic REMOVE_BINDINGS,
  input wire logic BIND_ENABLE,
  input wire logic SERVICE_ID_EVENT,
  input wire logic PROCESSOR_RESET_N,
  input wire logic STATUS_LAMP,
  input wire logic SERVICE_LAMP,
  input wire logic NET_ERROR_RED,
  input wire logic NET_ERROR_GREEN,
  input wire logic NET_ACTIVITY_LAMP,
  input wire logic EXPANSION_LAMP,
  input wire logic RELAY_ONE_LAMP,
  input wire logic RELAY_EIGHT_LAMP
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  logic r1_q;
  logic r2_q;
  // status, service, green and expansion lamps all lit means the lamp test is on
  wire lit = STATUS_LAMP & SERVICE_LAMP & NET_ERROR_GREEN & EXPANSION_LAMP;
  always_ff @(posedge CLOCK) begin
    r1_q <= RESET_N;
    r2_q <= r1_q;
  end
  // ***********
  // properties
  // ***********
  property p_relay;
    r2_q |-> lit || (RELAY_ONE_LAMP == $past(RELAY_COIL[0]) &&
      RELAY_EIGHT_LAMP == $past(RELAY_COIL[7]));
  endproperty
  a_relay: assert property (p_relay) else $error("relay lamp");
  property p_bind;
    r2_q |-> REMOVE_BINDINGS != BIND_ENABLE;
  endproperty
  a_bind: assert property (p_bind) else $error("bind flags");
  property p_id_pulse;
    SERVICE_ID_EVENT |=> !SERVICE_ID_EVENT;
  endproperty
  a_id_pulse: assert property (p_id_pulse) else $error("id pulse");
  property p_id_lamp;
    SERVICE_ID_EVENT |-> SERVICE_LAMP;
  endproperty
  a_id_lamp: assert property (p_id_lamp) else $error("id lamp");
  property p_rst;
    r2_q && $fell(PROCESSOR_RESET_N) |->
      $past(PROCESSOR_RESET_PUSHBUTTON, 2) &&
      $past(PROCESSOR_RESET_PUSHBUTTON, 4);
  endproperty
  a_rst: assert property (p_rst) else $error("cpu reset");
  property p_act;
    NET_ACTIVITY_EVENT |-> ##2 NET_ACTIVITY_LAMP [*8];
  endproperty
  a_act: assert property (p_act) else $error("net flash");
  property p_exp;
    r2_q && $rose(EXPANSION_LAMP) && !lit |-> $past(EXP_ACTIVITY_EVENT, 2);
  endproperty
  a_exp: assert property (p_exp) else $error("exp flash");
  property p_red;
    r2_q && NET_TEST_FAIL |=> NET_ERROR_RED && (!NET_ERROR_GREEN || lit);
  endproperty
  a_red: assert property (p_red) else $error("red lamp");
  property p_orange;
    r2_q && !NET_TEST_FAIL && !NODE_BOUND |=> NET_ERROR_RED && NET_ERROR_GREEN;
  endproperty
  a_orange: assert property (p_orange) else $error("orange lamp");
  property p_svc_on;
    r2_q && !APP_PRESENT && !WDOG_FATAL |=> SERVICE_LAMP;
  endproperty
  a_svc_on: assert property (p_svc_on) else $error("service on");
  c_id: cover property (SERVICE_ID_EVENT);
  c_act: cover property (NET_ACTIVITY_EVENT ##2 NET_ACTIVITY_LAMP);
  c_rst: cover property ($fell(PROCESSOR_RESET_N));
endmodule
bind isl_lamp_ctrl isl_lamp_ctrl_assertions u_chk (.*);

// >>> verif/isl_operator.sv
// operator model: switch bank, pushbuttons and activity events
`timescale 1ns/1ps
module isl_operator (
  input wire logic clk,
  output logic [7:0] sw,
  output logic svc,
  output logic rst_btn,
  output logic [1:0] ev
);
  initial begin
    sw = 8'h08;
    svc = 1'h0;
    rst_btn = 1'h0;
    ev = 2'h0;
  end
  task automatic set_sw(input logic [7:0] v);
    @(posedge clk);
    sw <= v;
  endtask
  // held until rel, as long as the caller wants
  task automatic press(input logic r);
    @(posedge clk);
    if (r) rst_btn <= 1'h1;
    else svc <= 1'h1;
  endtask
  task automatic rel();
    @(posedge clk);
    svc <= 1'h0;
    rst_btn <= 1'h0;
  endtask
  task automatic blip(input int i);
    @(posedge clk);
    ev[i] <= 1'h1;
    @(posedge clk);
    ev[i] <= 1'h0;
  endtask
endmodule

// >>> verif/tb_io_module_switch_led_control.sv
// testbench for the switch and lamp controller
`timescale 1ns/1ps
module tb_io_module_switch_led_control;
  logic CLOCK, RESET_N, APP_RUNNING, APP_PRESENT, APP_ERROR;
  logic NODE_INSTALLED, SELF_INSTALLED, WDOG_FATAL, NET_TEST_FAIL;
  logic NET_TEST_PASS, NODE_BOUND, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] NODE_SWITCH_BANK, RELAY_COIL;
  logic SERVICE_PUSHBUTTON, PROCESSOR_RESET_PUSHBUTTON;
  logic NET_ACTIVITY_EVENT, EXP_ACTIVITY_EVENT;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rv;
  logic REMOVE_BINDINGS, BIND_ENABLE, SERVICE_ID_EVENT, REBIND_REQUEST;
  logic PROCESSOR_RESET_N, STATUS_LAMP, SERVICE_LAMP, re;
  logic NET_ERROR_RED, NET_ERROR_GREEN, NET_ACTIVITY_LAMP, EXPANSION_LAMP;
  logic RELAY_ONE_LAMP, RELAY_TWO_LAMP, RELAY_THREE_LAMP, RELAY_FOUR_LAMP;
  logic RELAY_FIVE_LAMP, RELAY_SIX_LAMP, RELAY_SEVEN_LAMP, RELAY_EIGHT_LAMP;
  logic [3:0] NODE_ADDRESS;
  logic [2:0] AUTOBIND_SEL;
  logic [15:0] RELAY_DRIVE;
  int err_count, n_compared, n;
  wire [7:0] rl = {RELAY_EIGHT_LAMP, RELAY_SEVEN_LAMP, RELAY_SIX_LAMP,
    RELAY_FIVE_LAMP, RELAY_FOUR_LAMP, RELAY_THREE_LAMP, RELAY_TWO_LAMP,
    RELAY_ONE_LAMP};
  isl_lamp_ctrl #(.TICK_CYC(20), .DEBOUNCE_CYC(4), .STRETCH_CYC(10)) DUT (
    .CLOCK, .RESET_N, .NODE_SWITCH_BANK, .SERVICE_PUSHBUTTON,
    .PROCESSOR_RESET_PUSHBUTTON, .APP_RUNNING, .APP_PRESENT, .APP_ERROR,
    .NODE_INSTALLED, .SELF_INSTALLED, .WDOG_FATAL, .NET_TEST_FAIL,
    .NET_TEST_PASS, .NODE_BOUND, .NET_ACTIVITY_EVENT, .EXP_ACTIVITY_EVENT,
    .RELAY_COIL, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .NODE_ADDRESS, .AUTOBIND_SEL, .REMOVE_BINDINGS,
    .BIND_ENABLE, .SERVICE_ID_EVENT, .REBIND_REQUEST, .PROCESSOR_RESET_N,
    .RELAY_DRIVE, .STATUS_LAMP, .SERVICE_LAMP, .NET_ERROR_RED,
    .NET_ERROR_GREEN, .NET_ACTIVITY_LAMP, .EXPANSION_LAMP, .RELAY_ONE_LAMP,
    .RELAY_TWO_LAMP, .RELAY_THREE_LAMP, .RELAY_FOUR_LAMP, .RELAY_FIVE_LAMP,
    .RELAY_SIX_LAMP, .RELAY_SEVEN_LAMP, .RELAY_EIGHT_LAMP);
  isl_operator op (.clk(CLOCK), .sw(NODE_SWITCH_BANK),
    .svc(SERVICE_PUSHBUTTON), .rst_btn(PROCESSOR_RESET_PUSHBUTTON),
    .ev({EXP_ACTIVITY_EVENT, NET_ACTIVITY_EVENT}));
  initial begin
    CLOCK = 1'h0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  // ***********
  // helpers
  // ***********
  task automatic complete_run();
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int k;
    @(posedge CLOCK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'h1;
    k = 0;
    do begin
      @(posedge CLOCK);
      k++;
      if (k > 20) begin
        chk("pready", 1, 0);
        complete_run();
      end
    end while (PREADY !== 1'h1);
    rv = PRDATA;
    re = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  function automatic logic sig(input int i);
    case (i)
      0: return STATUS_LAMP;
      1: return SERVICE_LAMP;
      2: return NET_ACTIVITY_LAMP;
      3: return EXPANSION_LAMP;
      4: return SERVICE_ID_EVENT;
      5: return REBIND_REQUEST;
      default: return !PROCESSOR_RESET_N;
    endcase
  endfunction
  task automatic wait_v(input int i, input logic v, input int lim);
    int k;
    k = 0;
    while (sig(i) !== v) begin
      @(posedge CLOCK);
      k++;
      if (k > lim) begin
        chk($sformatf("wait %0d", i), v, sig(i));
        complete_run();
      end
    end
  endtask
  task automatic run_len(input int i, input int lim);
    wait_v(i, 1'h0, lim);
    wait_v(i, 1'h1, lim);
    n = 0;
    while (sig(i) === 1'h1 && n < 5000) begin
      @(posedge CLOCK);
      n++;
    end
  endtask
  task automatic rises(input int i, input int cyc);
    logic p;
    p = sig(i);
    n = 0;
    repeat (cyc) begin
      @(posedge CLOCK);
      if (sig(i) === 1'h1 && p !== 1'h1) begin
        n++;
      end
      p = sig(i);
    end
  endtask
  // ***********
  // main sequence
  // ***********
  initial begin
    {RESET_N, APP_RUNNING, APP_ERROR, SELF_INSTALLED, WDOG_FATAL} = 5'h0;
    {NET_TEST_FAIL, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {APP_PRESENT, NODE_INSTALLED, NET_TEST_PASS, NODE_BOUND} = 4'hF;
    RELAY_COIL = 8'h00;
    err_count = 0;
    n_compared = 0;
    repeat (3) @(posedge CLOCK);
    RESET_N <= 1'h1;
    repeat (3) @(posedge CLOCK);
    chk("addr", 4'h8, NODE_ADDRESS);
    chk("bind", 2'h1, {REMOVE_BINDINGS, BIND_ENABLE});
    chk("cpu rst", 1'h1, PROCESSOR_RESET_N);
    apb(1'h0, 12'h000, 32'h0);
    chk("ctrl", 32'h0, rv);
    apb(1'h1, 12'h000, 32'h1);
    apb(1'h0, 12'h000, 32'h0);
    chk("ctrl rw", 32'h1, rv);
    chk("lamp test", 14'h3FFF, {rl, STATUS_LAMP, SERVICE_LAMP, NET_ERROR_RED,
      NET_ERROR_GREEN, NET_ACTIVITY_LAMP, EXPANSION_LAMP});
    apb(1'h1, 12'h000, 32'h0);
    apb(1'h1, 12'h004, 32'h0000_A5C3);
    apb(1'h0, 12'h004, 32'h0);
    chk("relay", 32'h0000_A5C3, rv);
    chk("drive", 16'hA5C3, RELAY_DRIVE);
    apb(1'h1, 12'h008, 32'hFFFF_FFFF);
    chk("ro err", 1'h1, re);
    apb(1'h0, 12'h008, 32'h0);
    chk("status sw", 8'h08, rv[7:0]);
    apb(1'h0, 12'h00C, 32'h0);
    chk("unmapped err", 1'h1, re);
    chk("unmapped data", 32'h0, rv);
    op.set_sw(8'hF5);
    repeat (10) @(posedge CLOCK);
    chk("sw", 7'h75, {AUTOBIND_SEL, NODE_ADDRESS});
    op.set_sw(8'h75);
    repeat (10) @(posedge CLOCK);
    chk("sw8", 7'h75, {AUTOBIND_SEL, NODE_ADDRESS});
    for (int i = 0; i < 8; i++) begin
      RELAY_COIL <= 8'h01 << i;
      repeat (3) @(posedge CLOCK);
      chk("coil", 8'h01 << i, rl);
    end
    for (int i = 0; i < 8; i++) begin
      {NET_TEST_FAIL, NET_TEST_PASS, NODE_BOUND} <= i[2:0];
      repeat (3) @(posedge CLOCK);
      chk("net", i[2] ? 2'h2 : !i[0] ? 2'h3 : i[1] ? 2'h1 : 2'h0,
        {NET_ERROR_RED, NET_ERROR_GREEN});
    end
    fork
      op.blip(0);
      run_len(2, 20);
    join
    chk("net flash", 10, n);
    fork
      begin
        op.blip(1);
        op.blip(1);
      end
      run_len(3, 20);
    join
    chk("exp flash", 12, n);
    APP_RUNNING <= 1'h1;
    repeat (2) @(posedge CLOCK);
    run_len(0, 500);
    chk("run blink", 200, n);
    SELF_INSTALLED <= 1'h1;
    op.set_sw(8'h02);
    repeat (10) @(posedge CLOCK);
    rises(0, 1300);
    rises(0, 1200);
    chk("self blinks", 2, n);
    op.set_sw(8'h00);
    repeat (10) @(posedge CLOCK);
    chk("remove", 1'h1, REMOVE_BINDINGS);
    rises(0, 4000);
    chk("addr0 dark", 0, n);
    op.set_sw(8'h02);
    repeat (10) @(posedge CLOCK);
    chk("svc off", 1'h0, SERVICE_LAMP);
    op.press(1'h0);
    op.rel();
    rises(4, 10);
    chk("glitch", 0, n);
    op.press(1'h0);
    wait_v(4, 1'h1, 20);
    chk("svc held", 1'h1, SERVICE_LAMP);
    wait_v(5, 1'h1, 900);
    op.rel();
    APP_PRESENT <= 1'h0;
    repeat (10) @(posedge CLOCK);
    chk("no app", 1'h1, SERVICE_LAMP);
    APP_PRESENT <= 1'h1;
    APP_ERROR <= 1'h1;
    repeat (3) @(posedge CLOCK);
    chk("app error", 1'h1, SERVICE_LAMP);
    APP_ERROR <= 1'h0;
    NODE_INSTALLED <= 1'h0;
    run_len(1, 900);
    chk("uninst", 400, n);
    WDOG_FATAL <= 1'h1;
    repeat (2) @(posedge CLOCK);
    run_len(1, 1100);
    chk("fatal", 40, n);
    rises(1, 1000);
    chk("fatal rate", 1, n);
    op.press(1'h1);
    wait_v(6, 1'h1, 20);
    op.rel();
    wait_v(6, 1'h0, 20);
    RESET_N <= 1'h0;
    repeat (2) @(posedge CLOCK);
    chk("in reset", 10'h000, {rl, SERVICE_LAMP, PROCESSOR_RESET_N});
    RESET_N <= 1'h1;
    repeat (2) @(posedge CLOCK);
    chk("rst addr", 4'h8, NODE_ADDRESS);
    complete_run();
  end
endmodule
